// *** src/nvepc_map.svh ***
// Purpose: Register offsets, field positions, reset values and counts.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave.
// Notes:   Definitions only.
`ifndef NVEPC_MAP_SVH
`define NVEPC_MAP_SVH
`define NVEPC_OFF_EN_SET     8'h00
`define NVEPC_OFF_EN_CLR     8'h04
`define NVEPC_OFF_PEND_SET   8'h08
`define NVEPC_OFF_PEND_CLR   8'h0C
`define NVEPC_OFF_CTRL_STATE 8'h10
`define NVEPC_OFF_PRIO       8'h14
`define NVEPC_OFF_GLOBAL_PRIORITY_MASK_REG    8'h18
`define NVEPC_OFF_CONTROL    8'h1C
`define NVEPC_OFF_MSP        8'h20
`define NVEPC_OFF_PSP        8'h24
`define NVEPC_ACT_LSB        0
`define NVEPC_PEND_NUM_LSB   12
`define NVEPC_ANY_PEND_BIT   22
`define NVEPC_MASK_BIT       0
`define NVEPC_SPSEL_BIT      0
`define NVEPC_RST_EN         16'h0000
`define NVEPC_RST_PRIO       32'h0000_0000
`define NVEPC_RST_SP         32'h0000_0000
`define NVEPC_IRQ_BASE       9'h010
`define NVEPC_FRAME_WORDS    3'h7
`define NVEPC_WORD_BYTES     32'h0000_0004
`define NVEPC_FRAME_BYTES    32'h0000_0020
`define NVEPC_MAX_NEST       3'h4
`endif

// *** src/nvepc_pkg.sv ***
// Purpose: Types shared by the enable/pending controller.
// Assumes: 16 peripheral lines, 2-bit priorities.
// Notes:   Constants live in nvepc_map.svh.
package nvepc_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_STACK} nvepc_fsm_t;
    typedef enum logic [1:0] {EX_INACTIVE, EX_PENDING, EX_ACTIVE, EX_ACT_PEND} nvepc_exc_state_t;
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } nvepc_avm_req_t;
    typedef struct packed {
        logic [31:0] psr;
        logic [31:0] ret_addr;
        logic [31:0] lr;
        logic [31:0] r12;
        logic [31:0] r3;
        logic [31:0] r2;
        logic [31:0] r1;
        logic [31:0] r0;
    } nvepc_frame_t;
    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [31:0] data;
    } nvepc_stack_wr_t;
    typedef struct packed {
        logic [15:0]      enable;
        logic [15:0]      pend;
        logic [15:0]      active;
        logic [31:0]      prio;
        logic             mask;
        logic             sp_sel;
        logic [31:0]      main_stack_pointer;
        logic [31:0]      process_stack_pointer;
        logic [2:0]       depth;
        logic [3:0][3:0]  nest;
        nvepc_fsm_t       fsm;
        logic [2:0]       cnt;
        logic [3:0]       cand;
        logic             waitreq;
        logic [31:0]      readdata;
        nvepc_stack_wr_t  stk;
        logic             start;
        logic [8:0]       vec;
        logic             handler;
    } nvepc_state_t;
endpackage : nvepc_pkg

// *** src/nvepc_ctrl.sv ***
// Purpose: Enable, pending and active tracking for 16 peripheral lines, with entry stacking.
// Assumes: Request lines and core share sys_clk_in; registers over Avalon-MM.
// Notes:   Every Avalon access takes two cycles; waitrequest drops in the second.
`timescale 1ns/1ps
`default_nettype none
`include "nvepc_map.svh"

// Overview of operation
// - Each of 16 lines has its own enable; disabled lines ignore requests.
// - Set-enable: write 1 sets enable, 0 no effect; read returns enables.
// - Clear-enable: write 1 clears enable, 0 no effect; read returns enables.
// - Enable and pending registers touch peripheral lines only, not system exceptions.
// - Global mask bit 0 blocks servicing; requests still pend, served after clear.
// - Priority levels 0..3, 0 highest; configurable exceptions obey the mask.
// - Every exception is inactive, pending, active or active-and-pending.
// - A preempted handler and its preemptor are both active together.
// - A new request during its own handler makes it active-and-pending.
// - Status bits 8:0 give executing exception number, zero in thread mode.
// - Status bits 20:12 give highest-priority pending number, zero if none.
// - Status bit 22 shows whether any peripheral line is pending.
// - Requests make an exception pending; handler start moves it to active.
// - Set-pending: write 1 marks pending, 0 no effect; read gives pending.
// - Clear-pending: write 1 removes pending, 0 no effect; read gives pending.
// - Setting an already set pending bit queues nothing extra.
// - Pending writable anytime; disabled line only pends once enabled.
// - Entry pushes eight words: PSR, return, LR, R12, R3, R2, R1, R0.
// - Thread mode uses selected stack pointer; handler mode always main pointer.
// - Stack grows downward; pointer holds last pushed word address.
// - Equal priorities resolve to the lowest exception number.
module nvepc_ctrl (
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_n_in,
    input  wire nvepc_pkg::nvepc_avm_req_t avm_req_in,
    output logic                          avm_waitrequest_out,
    output logic [31:0]                   avm_readdata_out,
    input  wire logic [15:0]              irq_in,
    input  wire nvepc_pkg::nvepc_frame_t  frame_in,
    input  wire logic                     exc_return_in,
    output nvepc_pkg::nvepc_stack_wr_t    stack_wr_out,
    output logic                          handler_start_out,
    output logic [8:0]                    active_exception_number_out,
    output logic                          handler_mode_out
);
    import nvepc_pkg::*;

    nvepc_state_t st;
    nvepc_state_t next_st;

    // ==========================================================
    // Helpers
    function automatic logic [1:0] prio_of(input logic [31:0] p, input logic [3:0] idx);
        prio_of = p[{idx, 1'b0} +: 2];
    endfunction : prio_of

    // Returns {found, index}; strict compare keeps the lowest number on ties
    function automatic logic [4:0] pick_top(input logic [15:0] req, input logic [31:0] p);
        logic       found;
        logic [3:0] best;
        found = 1'b0;
        best  = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (req[i] && (!found || prio_of(p, 4'(i)) < prio_of(p, best))) begin
                found = 1'b1;
                best  = 4'(i);
            end
        end
        pick_top = {found, best};
    endfunction : pick_top

    function automatic nvepc_exc_state_t exc_state(input logic pend, input logic act);
        case ({act, pend})
            2'b01:   exc_state = EX_PENDING;
            2'b10:   exc_state = EX_ACTIVE;
            2'b11:   exc_state = EX_ACT_PEND;
            default: exc_state = EX_INACTIVE;
        endcase
    endfunction : exc_state

    function automatic logic [31:0] frame_word(input nvepc_frame_t f, input logic [2:0] n);
        case (n)
            3'h0:    frame_word = f.psr;
            3'h1:    frame_word = f.ret_addr;
            3'h2:    frame_word = f.lr;
            3'h3:    frame_word = f.r12;
            3'h4:    frame_word = f.r3;
            3'h5:    frame_word = f.r2;
            3'h6:    frame_word = f.r1;
            default: frame_word = f.r0;
        endcase
    endfunction : frame_word

    // ==========================================================
    // Derived views
    logic [15:0] eff_pend;
    logic [4:0]  top_any;
    logic [4:0]  top_serv;
    logic [3:0]  cur_line;
    logic [8:0]  top_num;
    logic        acc;
    logic        use_psp;

    assign eff_pend = st.pend & st.enable;
    assign top_any  = pick_top(eff_pend, st.prio);
    assign top_serv = pick_top(eff_pend & ~st.active, st.prio);
    assign cur_line = (st.depth == 3'h0) ? 4'h0 : st.nest[2'(st.depth - 3'h1)];
    assign top_num  = top_any[4] ? (`NVEPC_IRQ_BASE | 9'(top_any[3:0])) : 9'h000;
    assign acc      = (avm_req_in.read || avm_req_in.write) && !st.waitreq;
    assign use_psp  = (st.depth == 3'h0) && st.sp_sel;

    // ==========================================================
    // Next state
    always_comb begin
        logic [31:0] wd;
        logic [31:0] sp;
        logic [15:0] hw_set;
        logic [3:0]  line;
        wd      = avm_req_in.writedata;
        sp      = 32'h0;
        line    = 4'h0;
        hw_set  = irq_in & st.enable;
        next_st = st;
        next_st.waitreq  = 1'b1;
        next_st.start    = 1'b0;
        next_st.stk.we   = 1'b0;

        // Avalon answer: drop waitrequest one cycle after the request is seen
        if ((avm_req_in.read || avm_req_in.write) && st.waitreq) begin
            next_st.waitreq  = 1'b0;
            next_st.readdata = 32'h0;
            case (avm_req_in.address)
                `NVEPC_OFF_EN_SET, `NVEPC_OFF_EN_CLR:     next_st.readdata = {16'h0, st.enable};
                `NVEPC_OFF_PEND_SET, `NVEPC_OFF_PEND_CLR: next_st.readdata = {16'h0, eff_pend};
                `NVEPC_OFF_CTRL_STATE: begin
                    next_st.readdata[`NVEPC_ACT_LSB +: 9]      = st.vec;
                    next_st.readdata[`NVEPC_PEND_NUM_LSB +: 9] = top_num;
                    next_st.readdata[`NVEPC_ANY_PEND_BIT]      = |eff_pend;
                end
                `NVEPC_OFF_PRIO:    next_st.readdata = st.prio;
                `NVEPC_OFF_GLOBAL_PRIORITY_MASK_REG: next_st.readdata[`NVEPC_MASK_BIT] = st.mask;
                `NVEPC_OFF_CONTROL: next_st.readdata[`NVEPC_SPSEL_BIT] = st.sp_sel;
                `NVEPC_OFF_MSP:     next_st.readdata = st.main_stack_pointer;
                `NVEPC_OFF_PSP:     next_st.readdata = st.process_stack_pointer;
                default:            next_st.readdata = 32'h0;
            endcase
        end

        // Register writes take effect at the accepting edge; upper 16 bits of enable and pending writes map to no line
        if (acc && avm_req_in.write) begin
            case (avm_req_in.address)
                `NVEPC_OFF_EN_SET:   next_st.enable = st.enable | wd[15:0];
                `NVEPC_OFF_EN_CLR:   next_st.enable = st.enable & ~wd[15:0];
                `NVEPC_OFF_PEND_SET: next_st.pend   = st.pend | wd[15:0];
                `NVEPC_OFF_PEND_CLR: next_st.pend   = st.pend & ~wd[15:0];
                `NVEPC_OFF_PRIO:     next_st.prio   = wd;
                `NVEPC_OFF_GLOBAL_PRIORITY_MASK_REG:  next_st.mask   = wd[`NVEPC_MASK_BIT];
                `NVEPC_OFF_CONTROL:  next_st.sp_sel = wd[`NVEPC_SPSEL_BIT];
                `NVEPC_OFF_MSP:      next_st.main_stack_pointer    = wd;
                `NVEPC_OFF_PSP:      next_st.process_stack_pointer    = wd;
                default: ;
            endcase
        end

        case (st.fsm)
            ST_IDLE: begin
                if (exc_return_in && st.depth != 3'h0) begin
                    line = cur_line;
                    next_st.active[line] = 1'b0;
                    next_st.depth = st.depth - 3'h1;
                    if (st.depth == 3'h1) begin
                        next_st.vec     = 9'h000;
                        next_st.handler = 1'b0;
                        if (st.sp_sel) next_st.process_stack_pointer = next_st.process_stack_pointer + `NVEPC_FRAME_BYTES;
                        else           next_st.main_stack_pointer = next_st.main_stack_pointer + `NVEPC_FRAME_BYTES;
                    end else begin
                        next_st.vec = `NVEPC_IRQ_BASE | 9'(st.nest[2'(st.depth - 3'h2)]);
                        next_st.main_stack_pointer = next_st.main_stack_pointer + `NVEPC_FRAME_BYTES;
                    end
                end else if (top_serv[4] && !st.mask && st.depth < `NVEPC_MAX_NEST &&
                             (st.depth == 3'h0 ||
                              prio_of(st.prio, top_serv[3:0]) < prio_of(st.prio, cur_line))) begin
                    next_st.fsm  = ST_STACK;
                    next_st.cand = top_serv[3:0];
                    next_st.cnt  = 3'h0;
                end
            end
            ST_STACK: begin
                sp = use_psp ? st.process_stack_pointer : st.main_stack_pointer;
                sp = sp - `NVEPC_WORD_BYTES;
                if (use_psp) next_st.process_stack_pointer = sp;
                else         next_st.main_stack_pointer = sp;
                next_st.stk.we   = 1'b1;
                next_st.stk.addr = sp;
                next_st.stk.data = frame_word(frame_in, st.cnt);
                next_st.cnt      = st.cnt + 3'h1;
                if (st.cnt == `NVEPC_FRAME_WORDS) begin
                    next_st.fsm              = ST_IDLE;
                    next_st.pend[st.cand]    = 1'b0;
                    next_st.active[st.cand]  = 1'b1;
                    next_st.nest[st.depth[1:0]] = st.cand;
                    next_st.depth            = st.depth + 3'h1;
                    next_st.vec              = `NVEPC_IRQ_BASE | 9'(st.cand);
                    next_st.handler          = 1'b1;
                    next_st.start            = 1'b1;
                end
            end
            default: next_st.fsm = ST_IDLE;
        endcase

        // Hardware requests win over any clear in the same cycle
        next_st.pend = next_st.pend | hw_set;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st          <= '0;
            st.enable   <= `NVEPC_RST_EN;
            st.prio     <= `NVEPC_RST_PRIO;
            st.main_stack_pointer      <= `NVEPC_RST_SP;
            st.process_stack_pointer      <= `NVEPC_RST_SP;
            st.fsm      <= ST_IDLE;
            st.waitreq  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign avm_waitrequest_out         = st.waitreq;
    assign avm_readdata_out            = st.readdata;
    assign stack_wr_out                = st.stk;
    assign handler_start_out           = st.start;
    assign active_exception_number_out = st.vec;
    assign handler_mode_out            = st.handler;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_disabled_ignored: assert property ((irq_in & ~st.enable) != 16'h0 && !(acc && avm_req_in.write)
        |=> ((st.pend & ~$past(st.pend)) & ~$past(st.enable)) == 16'h0)
        else $error("disabled line became pending");
    a_enable_set_w1s: assert property (acc && avm_req_in.write && avm_req_in.address == `NVEPC_OFF_EN_SET
        |=> st.enable == ($past(st.enable) | $past(avm_req_in.writedata[15:0])))
        else $error("set-enable write wrong");
    a_enable_clr_w1c: assert property (acc && avm_req_in.write && avm_req_in.address == `NVEPC_OFF_EN_CLR
        |=> st.enable == ($past(st.enable) & ~$past(avm_req_in.writedata[15:0])))
        else $error("clear-enable write wrong");
    a_mask_blocks: assert property (st.mask && st.fsm == ST_IDLE |=> st.fsm == ST_IDLE)
        else $error("entry started under global mask");
    a_no_equal_preempt: assert property (st.start && st.depth > 3'h1
        |-> prio_of(st.prio, st.nest[2'(st.depth - 3'h1)]) < prio_of(st.prio, st.nest[2'(st.depth - 3'h2)]))
        else $error("preemption without strictly higher priority");
    a_nested_active: assert property (st.start && st.depth > 3'h1
        |-> st.active[st.nest[2'(st.depth - 3'h2)]] && st.active[st.nest[2'(st.depth - 3'h1)]])
        else $error("preempted handler not active");
    a_vec_thread_zero: assert property (!st.handler |-> st.vec == 9'h000)
        else $error("active number nonzero in thread mode");
    a_eight_pushes: assert property ($rose(st.fsm == ST_STACK) |-> ##1 st.stk.we [*8] ##0 st.start)
        else $error("entry did not push eight words");
    a_stack_down: assert property (st.stk.we && $past(st.stk.we)
        |-> st.stk.addr == $past(st.stk.addr) - `NVEPC_WORD_BYTES)
        else $error("stack not growing downward");
    a_handler_msp: assert property (st.fsm == ST_STACK && st.depth != 3'h0 |=> st.process_stack_pointer == $past(st.process_stack_pointer))
        else $error("process stack used in handler mode");
    a_start_active: assert property (st.start |-> st.active[st.nest[2'(st.depth - 3'h1)]])
        else $error("started exception not active");
    a_any_pend_flag: assert property (acc && avm_req_in.read && avm_req_in.address == `NVEPC_OFF_CTRL_STATE
        |-> st.readdata[`NVEPC_ANY_PEND_BIT] == $past(|eff_pend))
        else $error("any-pending flag wrong");
    a_pend_set_w1s: assert property (acc && avm_req_in.write && st.fsm == ST_IDLE
        && avm_req_in.address == `NVEPC_OFF_PEND_SET
        |=> (st.pend & $past(avm_req_in.writedata[15:0])) == $past(avm_req_in.writedata[15:0]))
        else $error("set-pending write lost");
    a_pend_clr_w1c: assert property (acc && avm_req_in.write && avm_req_in.address == `NVEPC_OFF_PEND_CLR
        |=> (st.pend & $past(avm_req_in.writedata[15:0]) & ~$past(irq_in & st.enable)) == 16'h0)
        else $error("clear-pending write ignored");
    a_act_and_pend: assert property (st.fsm == ST_STACK && st.cnt == `NVEPC_FRAME_WORDS
        && irq_in[st.cand] && st.enable[st.cand] |=> st.active[st.cand] && st.pend[st.cand])
        else $error("request during own handler not kept pending");
    a_pend_to_active: assert property (st.fsm == ST_STACK && st.cnt == `NVEPC_FRAME_WORDS
        && !irq_in[st.cand] && !(acc && avm_req_in.write) |=> !st.pend[st.cand] && st.active[st.cand])
        else $error("entry did not move pending to active");
    a_thread_psp: assert property ($rose(st.fsm == ST_STACK) && st.depth == 3'h0 && st.sp_sel
        |=> st.stk.addr == $past(st.process_stack_pointer) - `NVEPC_WORD_BYTES)
        else $error("thread entry ignored the stack select");

    c_entry:      cover property (st.start);
    c_nested:     cover property (st.start && st.depth == 3'h2);
    c_act_pend:   cover property (exc_state(st.pend[cur_line], st.active[cur_line]) == EX_ACT_PEND);
    c_exc_return: cover property (exc_return_in && st.depth == 3'h1);
    c_masked_wait: cover property (st.mask && eff_pend != 16'h0);

endmodule : nvepc_ctrl
`default_nettype wire

// *** verif/nvepc_core_model.sv ***
// Purpose: Peripheral request lines and core side of the controller.
// Assumes: Same clock as the controller; requests and returns come from the bench.
// Notes:   Logs stack words; the log index wraps every eight words.
`timescale 1ns/1ps
`default_nettype none
module nvepc_core_model (
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_n_in,
    input  wire logic [15:0]             irq_req_in,
    input  wire logic                    ret_req_in,
    input  wire nvepc_pkg::nvepc_stack_wr_t stack_wr_in,
    output logic [15:0]                  irq_out,
    output nvepc_pkg::nvepc_frame_t      frame_out,
    output logic                         exc_return_out
);
    import nvepc_pkg::*;
    logic [31:0] wr_addr [0:7];
    logic [31:0] wr_data [0:7];
    int          wr_cnt;
    // Level requests, held as long as the peripheral wants service
    assign irq_out        = irq_req_in;
    assign exc_return_out = ret_req_in;
    // Core registers: word i of the frame carries its own index
    always_comb begin
        for (int i = 0; i < 8; i++) frame_out[i*32 +: 32] = 32'hC0DE_0000 | 32'(i);
    end
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wr_cnt <= 0;
        end else if (stack_wr_in.we === 1'b1) begin
            wr_addr[wr_cnt % 8] <= stack_wr_in.addr;
            wr_data[wr_cnt % 8] <= stack_wr_in.data;
            wr_cnt              <= wr_cnt + 1;
        end
    end
endmodule : nvepc_core_model
`default_nettype wire

// *** verif/tb_nested_irq_enable_pending_ctrl.sv ***
// Purpose: Self-checking bench for the enable/pending controller.
// Assumes: Avalon-MM master tasks; core model on the far side.
// Notes:   Expected values follow the register map and entry rules.
`timescale 1ns/1ps
`default_nettype none
module tb_nested_irq_enable_pending_ctrl;
    import nvepc_pkg::*;
    logic            sys_clk_in;
    logic            rst_n_in;
    nvepc_avm_req_t  avm_req;
    logic            waitreq;
    logic [31:0]     rdata;
    logic [15:0]     irq_req;
    logic [15:0]     irq_line;
    logic            ret_req;
    logic            ex_ret;
    nvepc_frame_t    frame;
    nvepc_stack_wr_t stk;
    logic            hstart;
    logic [8:0]      act_num;
    logic            hmode;
    int              fails;
    int              compares;

    nvepc_ctrl u_dut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .avm_req_in(avm_req),
        .avm_waitrequest_out(waitreq), .avm_readdata_out(rdata), .irq_in(irq_line),
        .frame_in(frame), .exc_return_in(ex_ret), .stack_wr_out(stk), .handler_start_out(hstart),
        .active_exception_number_out(act_num), .handler_mode_out(hmode)
    );
    nvepc_core_model u_core (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .irq_req_in(irq_req), .ret_req_in(ret_req),
        .stack_wr_in(stk), .irq_out(irq_line), .frame_out(frame), .exc_return_out(ex_ret)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // ==========================================================
    // Tasks
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
            fails++;
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        avm_req <= '{read: !wr, write: wr, address: a, writedata: d};
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (waitreq !== 1'b0 && n < 100);
        if (waitreq !== 1'b0) fails++;
        q = rdata;
        avm_req <= '0;
        // Idle edge keeps the next request from reusing this time step
        @(posedge sys_clk_in);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd_chk
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : tick
    task automatic start_wait(input int lim, input logic exp);
        logic got;
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge sys_clk_in);
            if (hstart === 1'b1) got = 1'b1;
        end
        chk({31'h0, got}, {31'h0, exp});
    endtask : start_wait
    task automatic chk_frame(input logic [31:0] base);
        // The last word is logged at the edge that shows the start pulse
        @(posedge sys_clk_in);
        for (int j = 0; j < 8; j++) begin
            chk(u_core.wr_addr[j], base - 32'(4 * (j + 1)));
            chk(u_core.wr_data[j], 32'hC0DE_0007 - 32'(j));
        end
    endtask : chk_frame
    task automatic ret;
        ret_req <= 1'b1;
        @(posedge sys_clk_in);
        ret_req <= 1'b0;
        tick(3);
    endtask : ret

    // ==========================================================
    // Main sequence
    initial begin
        rst_n_in = 1'b0;
        avm_req  = '0;
        irq_req  = '0;
        ret_req  = 1'b0;
        fails    = 0;
        compares = 0;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h10, 32'h0);
        wr(8'h14, 32'h0000_0880);
        wr(8'h20, 32'h0000_1000);
        wr(8'h18, 32'h1);
        rd_chk(8'h18, 32'h1);
        wr(8'h00, 32'hFFFF_0009);
        wr(8'h00, 32'h0);
        rd_chk(8'h00, 32'h9);
        wr(8'h04, 32'h1);
        rd_chk(8'h04, 32'h8);
        irq_req[1] <= 1'b1;
        tick(3);
        rd_chk(8'h08, 32'h0);
        irq_req[1] <= 1'b0;
        wr(8'h08, 32'h2);
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h10, 32'h0);
        wr(8'h00, 32'h2);
        rd_chk(8'h08, 32'h2);
        rd_chk(8'h10, 32'h0041_1000);
        wr(8'h0C, 32'h2);
        rd_chk(8'h0C, 32'h0);
        wr(8'h04, 32'h2);
        rd_chk(8'h30, 32'h0);
        // Masked request waits, then enters with the main pointer
        irq_req[3] <= 1'b1;
        start_wait(30, 1'b0);
        rd_chk(8'h10, 32'h0041_3000);
        wr(8'h18, 32'h0);
        start_wait(40, 1'b1);
        chk({23'h0, act_num}, 32'h13);
        chk({31'h0, hmode}, 32'h1);
        chk_frame(32'h0000_1000);
        rd_chk(8'h08, 32'h8);
        rd_chk(8'h20, 32'h0000_0FE0);
        irq_req[3] <= 1'b0;
        wr(8'h0C, 32'h8);
        // Equal priority waits, higher priority nests on the main pointer
        wr(8'h00, 32'h24);
        irq_req[5] <= 1'b1;
        start_wait(30, 1'b0);
        irq_req[2] <= 1'b1;
        start_wait(40, 1'b1);
        chk({23'h0, act_num}, 32'h12);
        irq_req <= 16'h0000;
        chk_frame(32'h0000_0FE0);
        wr(8'h0C, 32'h4);
        rd_chk(8'h10, 32'h0041_5012);
        wr(8'h0C, 32'h20);
        ret();
        chk({23'h0, act_num}, 32'h13);
        rd_chk(8'h20, 32'h0000_0FE0);
        ret();
        chk({22'h0, hmode, act_num}, 32'h0);
        rd_chk(8'h20, 32'h0000_1000);
        // Thread mode on the process pointer, tie broken by lowest number
        wr(8'h24, 32'h0000_2000);
        wr(8'h1C, 32'h1);
        wr(8'h18, 32'h1);
        wr(8'h00, 32'hC0);
        irq_req[7:6] <= 2'b11;
        tick(2);
        irq_req[7:6] <= 2'b00;
        wr(8'h08, 32'h40);
        wr(8'h08, 32'h40);
        rd_chk(8'h10, 32'h0041_6000);
        wr(8'h18, 32'h0);
        start_wait(40, 1'b1);
        chk({23'h0, act_num}, 32'h16);
        chk_frame(32'h0000_2000);
        rd_chk(8'h08, 32'h80);
        rd_chk(8'h20, 32'h0000_1000);
        start_wait(20, 1'b0);
        chk(32'(u_core.wr_cnt), 32'd24);
        // Reset in mid-handler returns every register to its idle value
        rst_n_in <= 1'b0;
        tick(2);
        rst_n_in <= 1'b1;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h20, 32'h0);
        chk({31'h0, hmode}, 32'h0);
        wrap_up();
    end
endmodule : tb_nested_irq_enable_pending_ctrl
`default_nettype wire
